/* File: mmg_seg_match.sv */
`timescale 1ns/10ps
`default_nettype none

// ==============================================================
// shared constants and types of the memory and register guard
package mmg_pkg;
	// table geometry
	localparam int SEG_NUM = 64;
	localparam int SEG_IDX_W = 6;
	localparam logic [15:0] SEG_ENTRY_BYTES = 16'h0008;
	// physical memory map, inclusive bounds
	localparam logic [15:0] ROM_TEST_LO = 16'h0000;
	localparam logic [15:0] ROM_TEST_HI = 16'h0fff;
	localparam logic [15:0] ROM_APP_HI = 16'h7fff;
	localparam logic [15:0] EE_MFR_LO = 16'h8000;
	localparam logic [15:0] EE_MFR_HI = 16'h807f;
	localparam logic [15:0] EE_COS_HI = 16'h8fff;
	localparam logic [15:0] EE_APP_HI = 16'hbfff;
	localparam logic [15:0] RAM_COS_LO = 16'hc000;
	localparam logic [15:0] RAM_COS_HI = 16'hc3ff;
	// register group boundaries, inclusive
	localparam logic [7:0] SFR_CPU_HI = 8'h3f;
	localparam logic [7:0] SFR_SYS_HI = 8'h5f;
	localparam logic [7:0] SFR_MMU_HI = 8'h67;
	localparam logic [7:0] SFR_FW_HI = 8'h6f;
	localparam logic [7:0] SFR_COS_HI = 8'h9f;
	localparam logic [7:0] SFR_TST_HI = 8'hbf;
	localparam logic [7:0] SFR_HW_HI = 8'hc7;
	// register addresses; all but the status word are kept inside this block
	localparam logic [7:0] SFR_PSW_ADDR = 8'h40;
	localparam logic [7:0] SFR_PTR_LO_ADDR = 8'h60;
	localparam logic [7:0] SFR_PTR_HI_ADDR = 8'h61;
	localparam logic [7:0] SFR_FWC_LO_ADDR = 8'h68;
	localparam logic [7:0] SFR_FWC_HI_ADDR = 8'h69;
	localparam logic [7:0] SFR_XB_LO_ADDR = 8'h6a;
	localparam logic [7:0] SFR_XB_HI_ADDR = 8'h6b;
	localparam logic [7:0] SFR_XS_LO_ADDR = 8'h6c;
	localparam logic [7:0] SFR_XS_HI_ADDR = 8'h6d;
	// reset values
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [7:0] FWC_RST = 8'h00;
	localparam logic [15:0] XCH_RST = 16'h0000;
	// mode bit positions
	localparam int PSW_COS_BIT = 5;
	localparam int PSW_SYS_BIT = 4;
	localparam int MBIT_BOOT = 0;
	localparam int MBIT_TEST = 1;

	typedef enum logic [2:0] {
		MODE_BOOT = 3'h0,
		MODE_TEST = 3'h1,
		MODE_COS = 3'h2,
		MODE_SYS = 3'h3,
		MODE_USER = 3'h4
	} mmg_mode_t;

	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_EXEC = 2'h2
	} mmg_op_t;

	// one table entry as fetched, 64 bits
	typedef struct packed {
		logic [10:0] rsvd;
		logic sfr_wr;
		logic sfr_rd;
		logic x;
		logic w;
		logic r;
		logic [15:0] first;
		logic [15:0] last;
		logic [15:0] offset;
	} mmg_seg_t;

	typedef struct packed {
		logic [15:0] vaddr;
		mmg_op_t op;
	} mmg_mreq_t;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [7:0] wdata;
	} mmg_sreq_t;
endpackage

// ==============================================================
// segment lookup: lowest enabled entry whose range holds the address
module mmg_seg_match (
	// table contents and address
	input wire mmg_pkg::mmg_seg_t [mmg_pkg::SEG_NUM-1:0] tab_i,
	input wire logic [15:0] vaddr_i,
	// result
	output logic hit_o,
	output logic [mmg_pkg::SEG_IDX_W-1:0] idx_o,
	output mmg_pkg::mmg_seg_t ent_o
);
	import mmg_pkg::*;

	// priority scan from the top so the lowest index wins
	always_comb begin
		hit_o = 1'b0;
		idx_o = '0;
		ent_o = '0;
		for (int i = SEG_NUM - 1; i >= 0; i--) begin
			// an entry with no rights at all is disabled
			if ((tab_i[i].r | tab_i[i].w | tab_i[i].x | tab_i[i].sfr_rd | tab_i[i].sfr_wr) && // RULE4
				vaddr_i >= tab_i[i].first && vaddr_i <= tab_i[i].last) begin
				hit_o = 1'b1;
				idx_o = SEG_IDX_W'(i);
				ent_o = tab_i[i];
			end
		end
	end
endmodule

`default_nettype wire

/* File: mmg_guard.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE1: mode from status register plus two bits
// RULE2: table entries hold rights, range, offset
// RULE3: entries also hold hardware register rights
// RULE4: entry without any right never matches
// RULE5: any number of segments up to 64
// RULE6: translate virtual address, check before access
// RULE7: memories split into dedicated and application regions
// RULE8: 128 manufacturer EEPROM bytes always reserved; test mode still reaches them
// RULE9: memory read/write/execute, registers read/write
// RULE10: every register access checked against mode
// RULE11: hardware rights from segment or firewall
// RULE12: denied read gives zero, write dropped
// RULE13: firewall and exchange window registers
// RULE14: boot mode memory rights
// RULE15: test mode full memory rights
// RULE16: contactless-os mode memory rights
// RULE17: table pointer register, entries fetched there
// RULE18: segmentation registers only in system mode
// RULE19: system full application rights, user per table
// RULE20: user miss or missing right denied
module mmg_guard (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// mode sources
	input wire logic [7:0] program_status_high_i,
	input wire logic [1:0] mode_bits_i,
	// memory request from the cpu
	input wire logic mem_valid_i,
	input wire mmg_pkg::mmg_mreq_t mem_req_i,
	output logic mem_ready_o,
	// memory answer, one cycle after acceptance
	output logic mem_rsp_valid_o,
	output logic mem_grant_o,
	output logic [15:0] mem_paddr_o,
	// segment table fetch port
	output logic tbl_req_o,
	output logic [15:0] tbl_addr_o,
	input wire logic tbl_ack_i,
	input wire logic [63:0] tbl_data_i,
	// register request from the cpu
	input wire logic sfr_valid_i,
	input wire mmg_pkg::mmg_sreq_t sfr_req_i,
	// external register file
	output logic sfr_ext_we_o,
	input wire logic [7:0] sfr_ext_rdata_i,
	// register answer, one cycle after the request
	output logic sfr_rsp_valid_o,
	output logic sfr_rsp_grant_o,
	output logic [7:0] sfr_rdata_o,
	// current mode
	output mmg_pkg::mmg_mode_t mode_o
);
	import mmg_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FETCH = 2'h1
	} mmg_state_t;

	// ==============================================================
	// mode decode
	mmg_mode_t mode;
	assign mode = mode_bits_i[MBIT_TEST] ? MODE_TEST : // RULE1
		mode_bits_i[MBIT_BOOT] ? MODE_BOOT :
		program_status_high_i[PSW_COS_BIT] ? MODE_COS :
		program_status_high_i[PSW_SYS_BIT] ? MODE_SYS : MODE_USER;
	assign mode_o = mode;

	// ==============================================================
	// configuration registers
	logic [15:0] tbl_ptr; // table base in memory
	logic [7:0] fwc_lo; // contactless-os read enables of hw registers
	logic [7:0] fwc_hi; // contactless-os write enables of hw registers
	logic [15:0] xch_base; // shared ram window base
	logic [15:0] xch_size; // shared ram window length
	mmg_seg_t [SEG_NUM-1:0] seg_tab; // cached table, all disabled at reset
	logic [1:0] exec_sfr; // hw rights of the segment code runs from
	mmg_state_t state;
	logic [SEG_IDX_W-1:0] fetch_idx;

	// ==============================================================
	// register access check
	wire [7:0] sa = sfr_req_i.addr;
	wire g_cpu = sa <= SFR_CPU_HI;
	wire g_sys = !g_cpu && sa <= SFR_SYS_HI;
	wire g_mmu = sa > SFR_SYS_HI && sa <= SFR_MMU_HI;
	wire g_fw = sa > SFR_MMU_HI && sa <= SFR_FW_HI;
	wire g_cos = sa > SFR_FW_HI && sa <= SFR_COS_HI;
	wire g_tst = sa > SFR_COS_HI && sa <= SFR_TST_HI;
	wire g_hw = sa > SFR_TST_HI && sa <= SFR_HW_HI;
	wire [2:0] hw_bit = sa[2:0];
	wire rd = !sfr_req_i.write; // RULE9
	wire m_full = mode == MODE_BOOT || mode == MODE_TEST;
	// hardware registers: firewall in contactless-os mode, segment in user mode
	wire hw_ok = m_full || mode == MODE_SYS ||
		(mode == MODE_COS && (rd ? fwc_lo[hw_bit] : fwc_hi[hw_bit])) || // RULE11 RULE13
		(mode == MODE_USER && (rd ? exec_sfr[0] : exec_sfr[1])); // RULE3 RULE11
	wire sfr_ok = g_cpu ||
		(g_sys && (m_full || mode == MODE_SYS || (rd && sa == SFR_PSW_ADDR))) ||
		(g_mmu && mode == MODE_SYS) || // RULE18
		(g_fw && (m_full || mode == MODE_SYS || (rd && mode == MODE_COS))) ||
		(g_cos && (m_full || mode == MODE_COS)) ||
		(g_tst && m_full) ||
		(g_hw && hw_ok); // RULE10
	wire sfr_go = sfr_valid_i && sfr_ok;
	wire sfr_wr_go = sfr_go && sfr_req_i.write;
	wire own_reg = g_mmu || g_fw;
	// denied writes never reach any register
	assign sfr_ext_we_o = sfr_wr_go && !own_reg; // RULE12

	// internal register read mux
	logic [7:0] own_rdata;
	always_comb begin
		case (sa)
			SFR_PTR_LO_ADDR: own_rdata = tbl_ptr[7:0];
			SFR_PTR_HI_ADDR: own_rdata = tbl_ptr[15:8];
			SFR_FWC_LO_ADDR: own_rdata = fwc_lo;
			SFR_FWC_HI_ADDR: own_rdata = fwc_hi;
			SFR_XB_LO_ADDR: own_rdata = xch_base[7:0];
			SFR_XB_HI_ADDR: own_rdata = xch_base[15:8];
			SFR_XS_LO_ADDR: own_rdata = xch_size[7:0];
			SFR_XS_HI_ADDR: own_rdata = xch_size[15:8];
			default: own_rdata = 8'h00;
		endcase
	end
	wire [7:0] sel_rdata = own_reg ? own_rdata : sfr_ext_rdata_i;
	wire ptr_hi_wr = sfr_wr_go && sa == SFR_PTR_HI_ADDR;

	// register answer; denied reads return zero
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sfr_rsp_valid_o <= 1'b0;
			sfr_rsp_grant_o <= 1'b0;
			sfr_rdata_o <= 8'h00;
		end else begin
			sfr_rsp_valid_o <= sfr_valid_i;
			sfr_rsp_grant_o <= sfr_go;
			sfr_rdata_o <= (sfr_go && rd) ? sel_rdata : 8'h00; // RULE12
		end
	end

	// writes of the registers kept in this block
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tbl_ptr <= PTR_RST;
			fwc_lo <= FWC_RST;
			fwc_hi <= FWC_RST;
			xch_base <= XCH_RST;
			xch_size <= XCH_RST;
		end else if (sfr_wr_go) begin
			case (sa)
				SFR_PTR_LO_ADDR: tbl_ptr[7:0] <= sfr_req_i.wdata; // RULE17
				SFR_PTR_HI_ADDR: tbl_ptr[15:8] <= sfr_req_i.wdata;
				SFR_FWC_LO_ADDR: fwc_lo <= sfr_req_i.wdata; // RULE13
				SFR_FWC_HI_ADDR: fwc_hi <= sfr_req_i.wdata;
				SFR_XB_LO_ADDR: xch_base[7:0] <= sfr_req_i.wdata;
				SFR_XB_HI_ADDR: xch_base[15:8] <= sfr_req_i.wdata;
				SFR_XS_LO_ADDR: xch_size[7:0] <= sfr_req_i.wdata;
				SFR_XS_HI_ADDR: xch_size[15:8] <= sfr_req_i.wdata;
				default: ;
			endcase
		end
	end

	// ==============================================================
	// table fetch: writing the high pointer byte while idle reloads all entries;
	// unused entries are simply stored with no rights
	assign tbl_req_o = state == ST_FETCH;
	assign tbl_addr_o = tbl_ptr + 16'({fetch_idx, 3'h0}); // RULE17
	wire fetch_last = fetch_idx == SEG_IDX_W'(SEG_NUM - 1);

	// fetch sequencer
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			fetch_idx <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					fetch_idx <= '0;
					if (ptr_hi_wr) begin
						state <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (tbl_ack_i) begin
						fetch_idx <= fetch_idx + 1'b1;
						if (fetch_last) begin
							state <= ST_IDLE;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// entry store
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			seg_tab <= '0;
		end else if (state == ST_FETCH && tbl_ack_i) begin
			seg_tab[fetch_idx] <= mmg_seg_t'(tbl_data_i); // RULE2 RULE5
		end
	end

	// ==============================================================
	// memory check; memory waits while the table is being reloaded
	assign mem_ready_o = state == ST_IDLE;
	wire mem_take = mem_valid_i && mem_ready_o;
	wire [15:0] va = mem_req_i.vaddr;
	wire op_r = mem_req_i.op == OP_READ;
	wire op_w = mem_req_i.op == OP_WRITE;
	wire op_x = mem_req_i.op == OP_EXEC;
	wire seg_hit;
	mmg_seg_t seg_ent;

	mmg_seg_match u_match (
		.tab_i(seg_tab),
		.vaddr_i(va),
		.hit_o(seg_hit),
		.idx_o(),
		.ent_o(seg_ent)
	);

	wire user = mode == MODE_USER;
	// only user code is relocated; other modes see physical addresses
	wire [15:0] pa = user ? va + seg_ent.offset : va; // RULE6
	wire r_rom_t = pa <= ROM_TEST_HI;
	wire r_rom_a = pa > ROM_TEST_HI && pa <= ROM_APP_HI;
	wire r_ee_m = pa >= EE_MFR_LO && pa <= EE_MFR_HI; // RULE8
	wire r_ee_c = pa > EE_MFR_HI && pa <= EE_COS_HI;
	wire r_ee_a = pa > EE_COS_HI && pa <= EE_APP_HI;
	wire r_ram_c = pa >= RAM_COS_LO && pa <= RAM_COS_HI;
	wire r_ram_a = pa > RAM_COS_HI; // RULE7
	wire [16:0] xch_end = {1'b0, xch_base} + {1'b0, xch_size};
	wire in_xch = pa >= xch_base && {1'b0, pa} < xch_end;
	// kind of access each memory allows at all
	wire rom_op = op_r || op_x;
	wire ram_op = op_r || op_w;
	wire cos_set = (r_rom_t && rom_op) || r_ee_c || (r_ram_c && ram_op);
	wire app_set = (r_rom_a && rom_op) || r_ee_a || (r_ram_a && ram_op);
	wire seg_op = (op_r && seg_ent.r) || (op_w && seg_ent.w) || (op_x && seg_ent.x);
	logic mem_ok;
	always_comb begin
		case (mode)
			MODE_BOOT: mem_ok = cos_set; // RULE14
			MODE_TEST: mem_ok = (pa <= ROM_APP_HI && rom_op) || (pa >= EE_MFR_LO &&
				pa <= EE_APP_HI) || (pa >= RAM_COS_LO && ram_op); // RULE15
			MODE_COS: mem_ok = cos_set || (r_ram_a && ram_op && in_xch); // RULE16
			MODE_SYS: mem_ok = app_set; // RULE19
			MODE_USER: mem_ok = seg_hit && seg_op && app_set; // RULE19 RULE20
			default: mem_ok = 1'b0;
		endcase
	end

	// memory answer and the hw rights of the executing segment
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_rsp_valid_o <= 1'b0;
			mem_grant_o <= 1'b0;
			mem_paddr_o <= 16'h0000;
			exec_sfr <= 2'h0;
		end else begin
			mem_rsp_valid_o <= mem_take;
			mem_grant_o <= mem_take && mem_ok;
			if (mem_take) begin
				mem_paddr_o <= pa;
			end
			if (mem_take && mem_ok && user && op_x) begin
				exec_sfr <= {seg_ent.sfr_wr, seg_ent.sfr_rd}; // RULE3
			end
		end
	end

	// ==============================================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence seq_ptr_write;
		sfr_valid_i && sfr_req_i.write && sa == SFR_PTR_HI_ADDR && mode == MODE_SYS &&
			state == ST_IDLE;
	endsequence
	sequence seq_fetch_begin;
		tbl_req_o && tbl_addr_o == tbl_ptr && !mem_ready_o;
	endsequence

	reload_start_a: assert property (seq_ptr_write |=> seq_fetch_begin) // RULE17
		else $error("table reload did not start at entry zero");
	mmu_sys_only_a: assert property (sfr_valid_i && g_mmu && mode != MODE_SYS |=> // RULE18
		!sfr_rsp_grant_o && sfr_rdata_o == 8'h00)
		else $error("segmentation register reachable outside system mode");
	denied_read_zero_a: assert property (sfr_rsp_valid_o && !sfr_rsp_grant_o |-> // RULE12
		sfr_rdata_o == 8'h00)
		else $error("denied register read returned data");
	denied_write_drop_a: assert property (sfr_valid_i && sfr_req_i.write && !sfr_ok |-> // RULE12
		!sfr_ext_we_o ##1 ($stable(tbl_ptr) && $stable(fwc_lo) && $stable(fwc_hi) &&
		$stable(xch_base) && $stable(xch_size)))
		else $error("denied register write took effect");
	cpu_group_open_a: assert property (sfr_valid_i && g_cpu |=> sfr_rsp_grant_o) // RULE10
		else $error("general cpu register refused");
	mfr_reserved_a: assert property (mem_take && r_ee_m && mode != MODE_TEST |=> // RULE8
		mem_rsp_valid_o && !mem_grant_o)
		else $error("manufacturer eeprom bytes reached");
	boot_rom_ro_a: assert property (mem_take && mode == MODE_BOOT && pa <= ROM_APP_HI && // RULE14
		op_w |=> !mem_grant_o)
		else $error("rom write granted in boot mode");
	test_ee_full_a: assert property (mem_take && mode == MODE_TEST && pa >= EE_MFR_LO && // RULE15
		pa <= EE_APP_HI |=> mem_grant_o)
		else $error("eeprom access refused in test mode");
	user_miss_a: assert property (mem_take && user && !seg_hit |=> !mem_grant_o) // RULE20
		else $error("user access outside every segment granted");
	user_reloc_a: assert property (mem_take && user |=> // RULE6
		mem_paddr_o == $past(va) + $past(seg_ent.offset))
		else $error("user address not relocated by segment offset");
	// memory must come back right after the last entry is stored
	fetch_stall_a: assert property (tbl_req_o && tbl_ack_i && fetch_last |=> // RULE6 RULE17
		mem_ready_o && !tbl_req_o)
		else $error("memory not released after the last table entry");
endmodule

`default_nettype wire

/* File: mmg_far_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ==============================================================
// far side: segment table memory and the external register file
module mmg_far_model (
	// clock
	input wire logic mclk_i,
	// table fetch port
	input wire logic tbl_req_i,
	input wire logic [15:0] tbl_addr_i,
	input wire logic slow_i,
	output logic tbl_ack_o,
	output logic [63:0] tbl_data_o,
	// external register file
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_we_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o
);
	logic [7:0] regs [256]; // register contents
	logic toggle; // paces the slow answers
	logic [5:0] idx; // entry index from the word address
	logic [63:0] ent; // entry at that index
	// the table base must be 512-byte aligned, the index is cut from the address
	assign idx = tbl_addr_i[8:3];
	// few entries defined, the rest stay disabled
	always_comb begin
		case (idx)
			6'h00: ent = {11'h0, 5'b00101, 16'h2000, 16'h20ff, 16'h1000};
			6'h01: ent = {11'h0, 5'b00000, 16'h4000, 16'h40ff, 16'h0000};
			6'h02: ent = {11'h0, 5'b00011, 16'h4000, 16'h40ff, 16'h5000};
			6'h03: ent = {11'h0, 5'b01100, 16'h5000, 16'h50ff, 16'h0000};
			6'h3f: ent = {11'h0, 5'b00011, 16'h6000, 16'h60ff, 16'h6400};
			default: ent = 64'h0;
		endcase
	end
	// slow mode acks every other cycle; data off an ack is scrambled
	assign tbl_ack_o = tbl_req_i & (~slow_i | toggle);
	assign tbl_data_o = tbl_ack_o ? ent : ~ent;
	assign sfr_rdata_o = regs[sfr_addr_i];
	// register writes land on the clock edge while the strobe is high
	always @(posedge mclk_i) begin
		toggle <= ~toggle;
		if (sfr_we_i) begin
			regs[sfr_addr_i] <= sfr_wdata_i;
		end
	end
	// contents follow the address so a stale read shows
	initial begin
		toggle = 1'b0;
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'(i) ^ 8'h5a;
		end
	end
endmodule
`default_nettype wire

/* File: tb_mmg_guard.sv */
`timescale 1ns/10ps
`default_nettype none

// ==============================================================
// bench: cpu accesses in every mode with expected answers
module tb_mmg_guard;
	import mmg_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] psw = 8'h00;
	logic [1:0] mbits = 2'b00;
	logic mem_valid = 1'b0;
	mmg_mreq_t mem_req = '0;
	logic sfr_valid = 1'b0;
	mmg_sreq_t sfr_req = '0;
	logic slow = 1'b0; // full rate first, so the entries in use come from the slow load
	logic mem_ready, mem_rsp, mem_grant, tbl_req, tbl_ack, ext_we, sfr_rsp, sfr_grant;
	logic [15:0] mem_paddr, tbl_addr;
	logic [63:0] tbl_data;
	logic [7:0] ext_rdata, sfr_rdata;
	mmg_mode_t mode;
	int fails = 0;
	int n_tests = 0;

	always #5 mclk_i = ~mclk_i;

	mmg_guard dut (.mclk_i(mclk_i), .rst_i(rst_i), .program_status_high_i(psw),
		.mode_bits_i(mbits), .mem_valid_i(mem_valid), .mem_req_i(mem_req),
		.mem_ready_o(mem_ready), .mem_rsp_valid_o(mem_rsp), .mem_grant_o(mem_grant),
		.mem_paddr_o(mem_paddr), .tbl_req_o(tbl_req), .tbl_addr_o(tbl_addr),
		.tbl_ack_i(tbl_ack), .tbl_data_i(tbl_data), .sfr_valid_i(sfr_valid),
		.sfr_req_i(sfr_req), .sfr_ext_we_o(ext_we), .sfr_ext_rdata_i(ext_rdata),
		.sfr_rsp_valid_o(sfr_rsp), .sfr_rsp_grant_o(sfr_grant), .sfr_rdata_o(sfr_rdata),
		.mode_o(mode));

	mmg_far_model far (.mclk_i(mclk_i), .tbl_req_i(tbl_req), .tbl_addr_i(tbl_addr),
		.slow_i(slow), .tbl_ack_o(tbl_ack), .tbl_data_o(tbl_data),
		.sfr_addr_i(sfr_req.addr), .sfr_we_i(ext_we), .sfr_wdata_i(sfr_req.wdata),
		.sfr_rdata_o(ext_rdata));

	// one compare, counted
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (e !== g) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// junk in unrelated status bits must not move the mode
	task automatic setm(mmg_mode_t m);
		mem_valid = 1'b0;
		sfr_valid = 1'b0;
		psw = (m == MODE_COS) ? 8'h30 : (m == MODE_SYS) ? 8'h1f : 8'h0f;
		mbits = (m == MODE_TEST) ? 2'b10 : (m == MODE_BOOT) ? 2'b01 : 2'b00;
		@(posedge mclk_i);
		#1;
		chk("mode", 16'(m), 16'(mode));
	endtask

	// memory access, answer one cycle after the take
	task automatic macc(logic [15:0] va, mmg_op_t op, logic g, logic [15:0] pa);
		sfr_valid = 1'b0;
		mem_valid = 1'b1;
		mem_req = '{vaddr: va, op: op};
		chk("mem ready", 16'h1, 16'(mem_ready));
		@(posedge mclk_i);
		#1;
		chk("mem rsp", 16'h1, 16'(mem_rsp));
		chk("mem grant", 16'(g), 16'(mem_grant));
		if (g) begin
			chk("paddr", pa, mem_paddr);
		end
	endtask

	// register access; a denied or write answer carries zero data
	task automatic sacc(logic [7:0] a, logic w, logic [7:0] d, logic g, logic [7:0] rd);
		mem_valid = 1'b0;
		sfr_valid = 1'b1;
		sfr_req = '{addr: a, write: w, wdata: d};
		#1;
		chk("ext we", 16'(w & g & (a[7:4] != 4'h6)), 16'(ext_we));
		@(posedge mclk_i);
		#1;
		chk("sfr rsp", 16'h1, 16'(sfr_rsp));
		chk("sfr grant", 16'(g), 16'(sfr_grant));
		chk("sfr rdata", (g & !w) ? 16'(rd) : 16'h0, 16'(sfr_rdata));
	endtask

	function automatic logic [7:0] ev(logic [7:0] a);
		return a ^ 8'h5a;
	endfunction

	// table reload after the pointer high byte; memory waits meanwhile
	task automatic reload();
		int k;
		sfr_valid = 1'b0;
		chk("tbl req", 16'h1, 16'(tbl_req));
		chk("busy ready", 16'h0, 16'(mem_ready));
		chk("tbl addr", 16'h8200, tbl_addr);
		k = 0;
		while (mem_ready !== 1'b1 && k < 400) begin
			@(posedge mclk_i);
			#1;
			k++;
		end
		if (k >= 400) begin
			fails++;
			$display("wrong value reload expected done seen hang");
			wrap_up();
		end
		// at full rate one entry lands per cycle
		if (!slow) begin
			chk("reload cycles", 16'h0040, 16'(k));
		end
	endtask

	// hang guard
	initial begin
		#1000000;
		fails++;
		$display("wrong value run expected end seen hang");
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge mclk_i);
		#1;
		rst_i = 1'b0;
		setm(MODE_BOOT);
		macc(16'h0fff, OP_EXEC, 1, 16'h0fff);
		macc(16'h1000, OP_READ, 0, 16'h0);
		macc(16'h0000, OP_WRITE, 0, 16'h0);
		macc(16'h807f, OP_READ, 0, 16'h0);
		macc(16'h8080, OP_WRITE, 1, 16'h8080);
		macc(16'h9000, OP_READ, 0, 16'h0);
		macc(16'hc3ff, OP_WRITE, 1, 16'hc3ff);
		macc(16'hc000, OP_EXEC, 0, 16'h0);
		sacc(8'ha0, 0, 8'h0, 1, ev(8'ha0));
		sacc(8'h60, 0, 8'h0, 0, 8'h0);
		setm(MODE_SYS);
		sacc(8'h60, 1, 8'h00, 1, 8'h0);
		sacc(8'h61, 1, 8'h82, 1, 8'h0);
		reload();
		slow = 1'b1;
		sacc(8'h61, 1, 8'h82, 1, 8'h0);
		reload();
		sacc(8'h61, 0, 8'h0, 1, 8'h82);
		sacc(8'h68, 1, 8'h01, 1, 8'h0);
		sacc(8'h69, 1, 8'h02, 1, 8'h0);
		sacc(8'h6b, 1, 8'hc4, 1, 8'h0);
		sacc(8'h6c, 1, 8'h10, 1, 8'h0);
		sacc(8'h6b, 0, 8'h0, 1, 8'hc4);
		sacc(8'h6d, 0, 8'h0, 1, 8'h00);
		sacc(8'h50, 0, 8'h0, 1, ev(8'h50));
		sacc(8'h70, 0, 8'h0, 0, 8'h0);
		sacc(8'hc8, 0, 8'h0, 0, 8'h0);
		macc(16'h1000, OP_EXEC, 1, 16'h1000);
		macc(16'h0fff, OP_READ, 0, 16'h0);
		macc(16'h8fff, OP_READ, 0, 16'h0);
		macc(16'h9000, OP_WRITE, 1, 16'h9000);
		macc(16'hc400, OP_WRITE, 1, 16'hc400);
		macc(16'hffff, OP_EXEC, 0, 16'h0);
		setm(MODE_COS);
		macc(16'h0fff, OP_READ, 1, 16'h0fff);
		macc(16'h8fff, OP_EXEC, 1, 16'h8fff);
		macc(16'hc40f, OP_WRITE, 1, 16'hc40f);
		macc(16'hc410, OP_WRITE, 0, 16'h0);
		sacc(8'hc0, 0, 8'h0, 1, ev(8'hc0));
		sacc(8'hc1, 0, 8'h0, 0, 8'h0);
		sacc(8'hc1, 1, 8'h33, 1, 8'h0);
		sacc(8'hc0, 1, 8'h44, 0, 8'h0);
		sacc(8'h68, 0, 8'h0, 1, 8'h01);
		sacc(8'h68, 1, 8'hff, 0, 8'h0);
		sacc(8'h60, 0, 8'h0, 0, 8'h0);
		setm(MODE_USER);
		sacc(8'hc0, 0, 8'h0, 0, 8'h0);
		macc(16'h2010, OP_READ, 1, 16'h3010);
		macc(16'h2010, OP_WRITE, 0, 16'h0);
		macc(16'h2010, OP_EXEC, 1, 16'h3010);
		macc(16'h4000, OP_WRITE, 1, 16'h9000);
		macc(16'h7000, OP_READ, 0, 16'h0);
		macc(16'h6000, OP_WRITE, 1, 16'hc400);
		macc(16'h6000, OP_EXEC, 0, 16'h0);
		macc(16'h5000, OP_EXEC, 1, 16'h5000);
		sacc(8'hc0, 0, 8'h0, 1, ev(8'hc0));
		sacc(8'hc0, 1, 8'h55, 0, 8'h0);
		sacc(8'h60, 1, 8'hff, 0, 8'h0);
		sacc(8'h40, 0, 8'h0, 1, ev(8'h40));
		sacc(8'h50, 0, 8'h0, 0, 8'h0);
		sacc(8'h21, 1, 8'h77, 1, 8'h0);
		sacc(8'h21, 0, 8'h0, 1, 8'h77);
		setm(MODE_TEST);
		sacc(8'hc0, 0, 8'h0, 1, ev(8'hc0));
		sacc(8'hc1, 0, 8'h0, 1, 8'h33);
		sacc(8'h61, 0, 8'h0, 0, 8'h0);
		macc(16'h7fff, OP_EXEC, 1, 16'h7fff);
		macc(16'h7fff, OP_WRITE, 0, 16'h0);
		macc(16'h8000, OP_WRITE, 1, 16'h8000);
		macc(16'hffff, OP_WRITE, 1, 16'hffff);
		setm(MODE_SYS);
		sacc(8'h60, 0, 8'h0, 1, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
